// *** src/irq_gating_defines.svh ***
// constants for the interrupt source gating block: offsets, field layout, reset values
// assumes a 32-bit Avalon-MM slave port with byte addresses
//
// How it works
// - a source whose block flag is set has its request dropped, never handled
// - nine group block flags: input groups 0..5, timer groups 6..8
// - with its block flag clear, a source's request is accepted into pending
// - accepted requests launch their handler promptly while the global permit stands and the executor is ready
// - one counter block flag drops all six counter interrupt sources
// - leaving run for stop clears every block flag
`ifndef IRQ_GATING_DEFINES_SVH
`define IRQ_GATING_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_BLOCK      5'h00
`define OFS_GLOBAL     5'h04
`define OFS_PENDING    5'h08
`define OFS_STATUS     5'h0C
`define OFS_MASK       5'h10

// ****************************************
// field layout
// ****************************************
`define NUM_SRC        15
`define NUM_BLOCK      10
`define NUM_INPUT      6
`define NUM_TIMER      3
`define NUM_COUNTER    6
`define BLK_COUNTER    9
`define GLB_PERMIT     0
`define GLB_INHIBIT    1
`define EVT_DROPPED    0
`define EVT_LAUNCHED   1
`define NUM_EVT        2

// ****************************************
// reset values
// ****************************************
`define RST_BLOCK      10'h000
`define RST_ENABLE     1'b0
`define RST_MASK       2'h0

`endif

// *** src/irq_gating_pkg.sv ***
// types for the interrupt source gating block
// assumes irq_gating_defines.svh is on the include path
`include "irq_gating_defines.svh"

package irq_gating_pkg;

  // ****************************************
  // bus slave states
  // ****************************************
  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_st_e;

  // ****************************************
  // whole state of the gating block
  // ****************************************
  typedef struct packed {
    bus_st_e                   bus_q;
    logic                      wait_q;
    logic [31:0]               rdata_q;
    logic [`NUM_BLOCK-1:0]     blk_q;
    logic                      en_q;
    logic [`NUM_SRC-1:0]       pend_q;
    logic [`NUM_INPUT-1:0]     s1_q;
    logic [`NUM_INPUT-1:0]     s2_q;
    logic [`NUM_INPUT-1:0]     s3_q;
    logic [`NUM_INPUT-1:0]     lvl_q;
    logic                      run_q;
    logic [`NUM_EVT-1:0]       stat_q;
    logic [`NUM_EVT-1:0]       mask_q;
    logic                      start_q;
    logic [3:0]                id_q;
    logic                      irq_q;
  } gate_state_s;

endpackage

// *** src/handler_select.sv ***
// picks the pending source whose handler launches next
// assumes pending bits from the gating block; lowest index wins
`timescale 1ns/1ps
`include "irq_gating_defines.svh"

module handler_select (
  // pending sources
  input  wire logic [`NUM_SRC-1:0] pending,
  // choice
  output logic                     any,
  output logic [3:0]               id
);

  always_comb begin
    any = 1'b0;
    id  = 4'h0;
    // scan downwards so the lowest set index is left last
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        any = 1'b1;
        id  = 4'(i);
      end
    end
  end

endmodule // handler_select

// *** src/interrupt_source_gating.sv ***
// per-source interrupt gating with global permit/inhibit and handler launch
// assumes one 200 MHz clock; input group pins are asynchronous, timers and counters are on this clock
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "irq_gating_defines.svh"

module interrupt_source_gating
  import irq_gating_pkg::*;
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        resetn,
  // avalon-mm slave
  input  wire logic [4:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // interrupt sources
  input  wire logic [`NUM_INPUT-1:0]       input_irq_pin,
  input  wire logic [`NUM_TIMER-1:0]       timer_irq,
  input  wire logic [`NUM_COUNTER-1:0]     counter_irq,
  // controller state and instructions
  input  wire logic                        run_mode,
  input  wire logic                        global_irq_permit,
  input  wire logic                        global_irq_inhibit,
  // program executor
  input  wire logic                        executor_ready,
  output logic                             handler_start,
  output logic [3:0]                       handler_id,
  // interrupt to software
  output logic                             irq
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  gate_state_s              st;
  gate_state_s              nx;
  logic [`NUM_SRC-1:0]      req;
  logic [`NUM_SRC-1:0]      blk15;
  logic [`NUM_SRC-1:0]      acc;
  logic                     sel_any;
  logic [3:0]               sel_id;
  logic                     launch;

  handler_select u_select (
    .pending (st.pend_q),
    .any     (sel_any),
    .id      (sel_id)
  );

  // ****************************************
  // source requests and acceptance
  // ****************************************
  // input groups fire on the debounced rising edge; timers and counters are one-cycle pulses
  assign req    = {counter_irq, timer_irq,
                   (st.s3_q & ~st.lvl_q & (st.s2_q ~^ st.s3_q))};
  assign blk15  = {{`NUM_COUNTER{st.blk_q[`BLK_COUNTER]}}, st.blk_q[`BLK_COUNTER-1:0]};
  assign acc    = req & ~blk15;
  assign launch = st.en_q & executor_ready & sel_any;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [31:0] m;
    logic [31:0] wd;
    logic [`NUM_SRC-1:0] clr;
    m   = lane_mask(avs_byteenable);
    wd  = avs_writedata & m;
    clr = '0;
    nx  = st;

    // three-stage pin synchroniser; level moves only when stages two and three agree
    nx.s1_q = input_irq_pin;
    nx.s2_q = st.s1_q;
    nx.s3_q = st.s2_q;
    for (int i = 0; i < `NUM_INPUT; i++) begin
      if (st.s2_q[i] == st.s3_q[i]) begin
        nx.lvl_q[i] = st.s3_q[i];
      end
    end

    // handler launch takes the lowest pending source
    nx.start_q = launch;
    if (launch) begin
      nx.id_q      = sel_id;
      clr[sel_id]  = 1'b1;
    end
    // a new acceptance wins over the launch clear
    nx.pend_q = (st.pend_q & ~clr) | acc;

    // global permit from instruction; inhibit wins when both arrive
    if (global_irq_inhibit) begin
      nx.en_q = 1'b0;
    end else if (global_irq_permit) begin
      nx.en_q = 1'b1;
    end

    // bus slave: one wait cycle, then answer
    case (st.bus_q)
      BUS_IDLE: begin
        nx.wait_q = 1'b1;
        if (avs_read || avs_write) begin
          nx.wait_q = 1'b0;
          nx.bus_q  = BUS_ANSWER;
          case (avs_address)
            `OFS_BLOCK:   nx.rdata_q = 32'(st.blk_q);
            `OFS_GLOBAL:  nx.rdata_q = 32'(st.en_q);
            `OFS_PENDING: nx.rdata_q = 32'(st.pend_q);
            `OFS_STATUS:  nx.rdata_q = 32'(st.stat_q);
            `OFS_MASK:    nx.rdata_q = 32'(st.mask_q);
            default:      nx.rdata_q = 32'h0000_0000;
          endcase
        end
      end
      BUS_ANSWER: begin
        nx.wait_q = 1'b1;
        nx.bus_q  = BUS_IDLE;
        if (avs_write) begin
          case (avs_address)
            `OFS_BLOCK: nx.blk_q = (st.blk_q & ~m[`NUM_BLOCK-1:0]) | wd[`NUM_BLOCK-1:0];
            `OFS_GLOBAL: begin
              if (wd[`GLB_INHIBIT]) begin
                nx.en_q = 1'b0;
              end else if (wd[`GLB_PERMIT] && !global_irq_inhibit) begin
                nx.en_q = 1'b1;
              end
            end
            `OFS_STATUS: nx.stat_q = st.stat_q & ~wd[`NUM_EVT-1:0];
            `OFS_MASK:   nx.mask_q = (st.mask_q & ~m[`NUM_EVT-1:0]) | wd[`NUM_EVT-1:0];
            default: begin
            end
          endcase
        end
      end
      default: begin
        nx.wait_q = 1'b1;
        nx.bus_q  = BUS_IDLE;
      end
    endcase

    // sticky events; a set in the clearing cycle survives
    if (|(req & blk15)) begin
      nx.stat_q[`EVT_DROPPED] = 1'b1;
    end
    if (launch) begin
      nx.stat_q[`EVT_LAUNCHED] = 1'b1;
    end

    // leaving run clears all block flags, overriding a software write
    nx.run_q = run_mode;
    if (st.run_q && !run_mode) begin
      nx.blk_q = `RST_BLOCK;
    end

    nx.irq_q = |(nx.stat_q & nx.mask_q);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st         <= '0;
      st.bus_q   <= BUS_IDLE;
      st.wait_q  <= 1'b1;
      st.blk_q   <= `RST_BLOCK;
      st.en_q    <= `RST_ENABLE;
      st.mask_q  <= `RST_MASK;
    end else begin
      st <= nx;
    end
  end

  assign avs_readdata    = st.rdata_q;
  assign avs_waitrequest = st.wait_q;
  assign handler_start   = st.start_q;
  assign handler_id      = st.id_q;
  assign irq             = st.irq_q;

  // ****************************************
  // checks
  // ****************************************
  sequence seq_held_off;
    !st.en_q && (st.pend_q != '0) && !global_irq_permit;
  endsequence

  sequence seq_ready_to_launch;
    st.en_q && executor_ready && (st.pend_q != '0);
  endsequence

  a_blocked_dropped: assert property (@(posedge clock) disable iff (!resetn)
    ((req & blk15 & ~st.pend_q) != '0) |=> ((st.pend_q & $past(req & blk15 & ~st.pend_q)) == '0))
    else $error("blocked request reached pending");

  a_counter_block: assert property (@(posedge clock) disable iff (!resetn)
    st.blk_q[`BLK_COUNTER] |-> (acc[`NUM_SRC-1:`NUM_SRC-`NUM_COUNTER] == '0))
    else $error("counter request accepted while blocked");

  a_accept_latch: assert property (@(posedge clock) disable iff (!resetn)
    (acc != '0) |=> ((st.pend_q & $past(acc)) == $past(acc)))
    else $error("accepted request not latched");

  a_launch_prompt: assert property (@(posedge clock) disable iff (!resetn)
    seq_ready_to_launch |=> handler_start ##0 (handler_id == $past(sel_id)))
    else $error("handler not launched while permitted");

  a_held_pending: assert property (@(posedge clock) disable iff (!resetn)
    seq_held_off |=> (!handler_start && ((st.pend_q & $past(st.pend_q)) == $past(st.pend_q))))
    else $error("pending lost or launched while inhibited");

  a_inhibit_blocks: assert property (@(posedge clock) disable iff (!resetn)
    global_irq_inhibit |=> !st.en_q ##1 !handler_start)
    else $error("launch after inhibit");

  a_stop_clears: assert property (@(posedge clock) disable iff (!resetn)
    (st.run_q && !run_mode) |=> (st.blk_q == '0))
    else $error("block flags kept on stop");

  a_launch_clears: assert property (@(posedge clock) disable iff (!resetn)
    launch |=> (st.pend_q[$past(sel_id)] == $past(acc[sel_id])))
    else $error("pending latch not cleared at launch");

  a_bus_answer: assert property (@(posedge clock) disable iff (!resetn)
    ((avs_read || avs_write) && avs_waitrequest) |-> ##[1:2] !avs_waitrequest)
    else $error("bus request left unanswered");

endmodule // interrupt_source_gating

// *** tb/irq_source_model.sv ***
// far side model: input pins, timers, counters and the program executor
// assumes the bench asks for one source at a time via fire/fire_id
`timescale 1ns/1ps

module irq_source_model (
  // clock
  input  wire logic       clock,
  // commands from the bench
  input  wire logic       fire,
  input  wire logic [3:0] fire_id,
  input  wire logic       stall,
  // sources and executor
  output logic [5:0]      pins,
  output logic [2:0]      timers,
  output logic [5:0]      counters,
  output logic            ready
);
  logic [2:0] hold_q [6];

  initial begin
    pins     = '0;
    timers   = '0;
    counters = '0;
    ready    = 1'b1;
    for (int i = 0; i < 6; i++) hold_q[i] = 3'd0;
  end

  // pins stay high a few cycles so the synchroniser sees a real edge
  always @(posedge clock) begin
    timers   <= '0;
    counters <= '0;
    ready    <= !stall;
    for (int i = 0; i < 6; i++) begin
      pins[i]   <= hold_q[i] != 3'd0;
      hold_q[i] <= (hold_q[i] != 3'd0) ? hold_q[i] - 3'd1 : 3'd0;
    end
    if (fire) begin
      if (fire_id < 4'd6) hold_q[fire_id] <= 3'd4;
      else if (fire_id < 4'd9) timers[fire_id - 4'd6] <= 1'b1;
      else counters[fire_id - 4'd9] <= 1'b1;
    end
  end
endmodule // irq_source_model

// *** tb/interrupt_source_gating_test.sv ***
// self-checking bench for the interrupt source gating block
// assumes the design files under src/ and the source model under tb/
`timescale 1ns/1ps
`include "irq_gating_defines.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end

module interrupt_source_gating_test;
  logic        clock, resetn, avs_read, avs_write, avs_waitrequest, run_mode, permit, inhibit;
  logic        ready, handler_start, irq, fire, stall;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  handler_id, fire_id, id;
  logic [5:0]  pins, counters;
  logic [2:0]  timers;
  logic [9:0]  blk;
  logic [3:0]  launched[$];
  int          error_cnt, total_checks, seed, cycles;

  // ****************************************
  // design and far side
  // ****************************************
  interrupt_source_gating i_interrupt_source_gating (.clock(clock), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .input_irq_pin(pins), .timer_irq(timers),
    .counter_irq(counters), .run_mode(run_mode), .global_irq_permit(permit),
    .global_irq_inhibit(inhibit), .executor_ready(ready), .handler_start(handler_start),
    .handler_id(handler_id), .irq(irq));
  irq_source_model i_irq_source_model (.clock(clock), .fire(fire), .fire_id(fire_id),
    .stall(stall), .pins(pins), .timers(timers), .counters(counters), .ready(ready));

  always #2.5 clock = !clock;

  // registered outputs are steady at the falling edge
  always @(negedge clock) if (handler_start === 1'b1) launched.push_back(handler_id);

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ****************************************
  // tasks and expectations
  // ****************************************
  function automatic logic accepted(input logic [9:0] b, input logic [3:0] s);
    return !b[(s < 4'd9) ? s : 4'd9];
  endfunction

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    // hold the request until waitrequest is sampled low at a rising edge
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) begin
      @(posedge clock);
      stall <= 1'($random(seed));
    end
    @(posedge clock);
    stall <= 1'b0;
  endtask

  task automatic fire_src(input logic [3:0] s);
    @(posedge clock);
    fire    <= 1'b1;
    fire_id <= s;
    @(posedge clock);
    fire    <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {clock, resetn, avs_read, avs_write, permit, inhibit, fire, stall} = '0;
    {avs_address, avs_writedata, fire_id} = '0;
    run_mode = 1'b1;
    seed = 3;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    bus(0, 5'h14, 0);
    `CHK("unmapped", 32'h0, rd)
    // inhibited after reset: every accepted source waits in its own latch
    for (int i = 0; i < 15; i++) fire_src(i[3:0]);
    settle(10);
    bus(0, `OFS_PENDING, 0);
    `CHK("pending", 32'h7FFF, rd)
    `CHK("early", 0, launched.size())
    @(posedge clock);
    permit <= 1'b1;
    @(posedge clock);
    permit <= 1'b0;
    settle(80);
    `CHK("count", 15, launched.size())
    for (int i = 0; i < 15 && i < launched.size(); i++) `CHK("order", i[3:0], launched[i])
    bus(0, `OFS_PENDING, 0);
    `CHK("drained", 32'h0, rd)
    // one block flag at a time, then random masks
    for (int k = 0; k < 24; k++) begin
      blk = (k < 10) ? (10'h1 << k) : 10'($random(seed));
      id  = (k < 9) ? k[3:0] : (k == 9) ? 4'd14 : 4'(($random(seed) & 32'h7FFF) % 15);
      bus(1, `OFS_BLOCK, {22'h0, blk});
      bus(1, `OFS_STATUS, 32'h3);
      launched.delete();
      fire_src(id);
      settle(20);
      `CHK("launch", accepted(blk, id) ? 1 : 0, launched.size())
      bus(0, `OFS_STATUS, 0);
      `CHK("dropped", !accepted(blk, id), rd[0])
    end
    // level interrupt from the launch event, masked and cleared
    bus(1, `OFS_BLOCK, 0);
    bus(1, `OFS_STATUS, 32'h3);
    bus(1, `OFS_MASK, 32'h2);
    fire_src(4'd6);
    settle(16);
    `CHK("irq_set", 1'b1, irq)
    bus(1, `OFS_STATUS, 32'h2);
    settle(3);
    `CHK("irq_clr", 1'b0, irq)
    bus(1, `OFS_MASK, 0);
    fire_src(4'd7);
    settle(16);
    `CHK("irq_mask", 1'b0, irq)
    // inhibit holds a request until the permit write
    @(posedge clock);
    inhibit <= 1'b1;
    @(posedge clock);
    inhibit <= 1'b0;
    launched.delete();
    fire_src(4'd8);
    settle(12);
    `CHK("held", 0, launched.size())
    bus(1, `OFS_GLOBAL, 32'h1);
    settle(20);
    `CHK("released", 1, launched.size())
    bus(0, `OFS_GLOBAL, 0);
    `CHK("permit_rd", 32'h1, rd)
    bus(1, `OFS_GLOBAL, 32'h2);
    bus(0, `OFS_GLOBAL, 0);
    `CHK("inhibit_rd", 32'h0, rd)
    // leaving run clears every block flag
    bus(1, `OFS_BLOCK, 32'h3FF);
    @(posedge clock);
    run_mode <= 1'b0;
    settle(3);
    bus(0, `OFS_BLOCK, 0);
    `CHK("stop_clear", 32'h0, rd)
    run_mode <= 1'b1;
    print_verdict();
  end
endmodule // interrupt_source_gating_test
